// ---- sse_card.sv ----
// Card end: bit-serial access logic of the secured EEPROM
// Contract
// - Power-up clears flags and address counter
// - Reset pin fall, clock low: address zero
// - Pin reset leaves every flag untouched
// - Counter advances on each clock fall outside a program cycle
// - Counter wraps to zero past 16383
// - Reset pin high blocks counter advance
// - Reset high, strobe and personalize low: standby
// - Readable bit driven after its clock fall
// - Unreadable bit: pin released, reads one
// - Compare: capture on rise, compare on fall
// - Code location plus flag selects compare
// - Write clears bit only when permitted
// - Host write: strobe, zero, rise, 5 ms
// - Erase sets whole containing byte to ones
// - Host erase: like write, one, 5 ms
// - New bit content shown after program fall
// - Strobe high programs; low reads, compares, verifies
// - Personalize high, fuse intact, code valid: open
// - Personalize low, fuse intact: full protection
// - Fuse blown: always full protection
`timescale 1ns/1ns
`include "sse_defines.svh"
module sse_card
  import sse_pkg::*;
#(
  parameter int PROG_CYC = `SSE_PROG_MS * 1000 * `SSE_CORE_MHZ
) (
  input  wire logic                   i_core_clk,      // Core clock, 20 MHz
  input  wire logic                   i_sys_rst,       // Power-on reset, async high
  sse_link_if.card                    lnk,             // Pins to the reader
  input  wire logic                   i_rd_en,         // Zone: read allowed at address
  input  wire logic                   i_wr_en,         // Zone: write allowed at address
  input  wire logic                   i_er_en,         // Zone: erase allowed at address
  input  wire logic                   i_code_loc,      // Zone: address is a code bit
  input  wire logic                   i_cmp_flag_en,   // Zone: code flag enables compare
  input  wire logic                   i_fuse_intact,   // Internal fuse not blown
  input  wire logic                   i_sc_valid,      // Master code validated
  output logic [`SSE_ADDR_W-1:0]      o_addr,          // Bit address counter
  output logic                        o_cmp_done,      // Compare performed, pulse
  output logic                        o_cmp_match,     // Last compared bit matched
  output logic                        o_cmp_fail,      // Sticky mismatch flag
  output logic                        o_prog_done,     // Program cycle ended, pulse
  output logic                        o_full_prot,     // Full protection in force
  output logic                        o_standby        // Low-power standby
);
  import sse_pkg::*;

  localparam logic [`SSE_SYNC_W-1:0] SYNC_RST = `SSE_SYNC_RST;

  logic [7:0]                 mem [`SSE_BYTES];
  logic [`SSE_SYNC_W-1:0]     sync1_ff;
  logic [`SSE_SYNC_W-1:0]     sync2_ff;
  logic [`SSE_SYNC_W-1:0]     prev_ff;
  logic                       cmp_bit_ff;
  logic                       cmp_arm_ff;
  prog_op_t                   op_ff;
  logic [31:0]                prog_cnt_ff;
  logic                       dev_io_oe_n_ff;

  // Synchronised pins: rst, clk, strobe, personalize, data
  wire [`SSE_SYNC_W-1:0] pins_raw = {lnk.rst_pin, lnk.clk_pin, lnk.program_strobe_pin,
                                     lnk.issuer_personalize_pin, lnk.io_line};

  genvar g;
  generate
    for (g = 0; g < `SSE_SYNC_W; g++) begin : g_sync
      always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          // Idle levels, so no false edge follows reset
          sync1_ff[g] <= SYNC_RST[g];
          sync2_ff[g] <= SYNC_RST[g];
          prev_ff[g]  <= SYNC_RST[g];
        end else begin
          sync1_ff[g] <= pins_raw[g];
          sync2_ff[g] <= sync1_ff[g];
          prev_ff[g]  <= sync2_ff[g];
        end
      end
    end
  endgenerate

  wire rst_s  = sync2_ff[4];
  wire clk_s  = sync2_ff[3];
  wire pgm_s  = sync2_ff[2];
  wire pers_s = sync2_ff[1];
  wire io_s   = sync2_ff[0];

  wire rst_fall = prev_ff[4] & ~rst_s;
  wire clk_rise = ~prev_ff[3] & clk_s;
  wire clk_fall = prev_ff[3] & ~clk_s;

  // Protection level from personalize pin, fuse and master code
  // issuer personalization opening
  wire pers_open = pers_s & i_fuse_intact & i_sc_valid;
  wire full_prot = ~pers_open;

  wire rd_ok = pers_open | i_rd_en;
  wire wr_ok = pers_open | i_wr_en;
  wire er_ok = pers_open | i_er_en;

  wire cmp_mode = i_code_loc & i_cmp_flag_en;

  wire standby = rst_s & ~pgm_s & ~pers_s;

  wire [`SSE_BYTE_ADDR_W-1:0] byte_idx = o_addr[`SSE_ADDR_W-1:3];
  wire [2:0]                  bit_idx  = o_addr[2:0];
  wire [7:0]                  cur_byte = mem[byte_idx];
  wire                        cur_bit  = cur_byte[bit_idx];

  wire prog_timed  = prog_cnt_ff >= 32'(PROG_CYC);
  wire prog_end    = clk_fall & ~rst_s & (op_ff != OP_NONE);
  wire do_write    = prog_end & prog_timed & (op_ff == OP_WRITE) & wr_ok;
  wire do_erase    = prog_end & prog_timed & (op_ff == OP_ERASE) & er_ok;
  wire step        = clk_fall & ~rst_s & (op_ff == OP_NONE);
  wire do_cmp      = step & cmp_arm_ff;

  // write clears only the addressed bit
  wire [7:0] cleared = cur_byte & ~(8'h01 << bit_idx);

  // strobe high frees line for program data
  wire nxt_oe_n = standby | cmp_mode | ~rd_ok | cur_bit | clk_rise | pgm_s;

  // Memory cell array, no reset on stored content
  always_ff @(posedge i_core_clk) begin
    if (do_write) begin
      mem[byte_idx] <= cleared;
    end else if (do_erase) begin
      mem[byte_idx] <= `SSE_ERASED_BYTE;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_addr <= `SSE_ADDR_ZERO;
    end else if (rst_fall & ~clk_s) begin
      o_addr <= `SSE_ADDR_ZERO;
    end else if (step) begin
      o_addr <= o_addr + `SSE_ADDR_ONE;
    end
  end

  // strobe high at rising edge starts programming
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      op_ff       <= OP_NONE;
      prog_cnt_ff <= '0;
    end else if (clk_rise & ~rst_s & pgm_s) begin
      // data level picks write or erase
      op_ff       <= io_s ? OP_ERASE : OP_WRITE;
      prog_cnt_ff <= '0;
    end else if (prog_end | rst_s) begin
      op_ff       <= OP_NONE;
    end else if ((op_ff != OP_NONE) & clk_s & ~prog_timed) begin
      prog_cnt_ff <= prog_cnt_ff + 32'd1;
    end
  end

  // capture code bit on rising edge
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cmp_bit_ff <= 1'b0;
      cmp_arm_ff <= 1'b0;
    end else if (clk_rise & ~rst_s & ~pgm_s) begin
      cmp_bit_ff <= io_s;
      cmp_arm_ff <= cmp_mode & rd_ok;
    end else if (clk_fall) begin
      cmp_arm_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cmp_done  <= 1'b0;
      o_cmp_match <= 1'b0;
      o_cmp_fail  <= 1'b0;
    end else begin
      o_cmp_done <= do_cmp;
      if (do_cmp) begin
        o_cmp_match <= cmp_bit_ff == cur_bit;
        o_cmp_fail  <= o_cmp_fail | (cmp_bit_ff != cur_bit);
      end
    end
  end

  // verify bit shown once program ends
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prog_done    <= 1'b0;
      dev_io_oe_n_ff <= 1'b1;
      o_full_prot    <= 1'b1;
      o_standby      <= 1'b0;
    end else begin
      o_prog_done    <= prog_end;
      dev_io_oe_n_ff <= nxt_oe_n;
      o_full_prot    <= full_prot;
      o_standby      <= standby;
    end
  end

  assign lnk.dev_io      = 1'b0;
  assign lnk.dev_io_oe_n = dev_io_oe_n_ff;
endmodule

// ---- sse_defines.svh ----
// Shared constants for the secured serial EEPROM bit-access ends
`ifndef SSE_DEFINES_SVH
`define SSE_DEFINES_SVH
`define SSE_ADDR_W        14
`define SSE_ADDR_ZERO     14'h0000
`define SSE_ADDR_ONE      14'h0001
`define SSE_BYTES         2048
`define SSE_BYTE_ADDR_W   11
`define SSE_ERASED_BYTE   8'hff
`define SSE_CORE_MHZ      20
`define SSE_PROG_MS       5
`define SSE_HALF_US       2
`define SSE_RST_HOLD_US   2
`define SSE_FIFO_DEPTH    8
`define SSE_SYNC_W        5
// Idle pin levels: reset and data lines pulled high
`define SSE_SYNC_RST      5'h11
`endif

// ---- sse_pkg.sv ----
// Types shared by both ends of the serial EEPROM link
package sse_pkg;
  typedef enum logic [2:0] {
    CMD_RESET,
    CMD_READ,
    CMD_CMP,
    CMD_WRITE,
    CMD_ERASE
  } cmd_t;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_WRITE,
    OP_ERASE
  } prog_op_t;
endpackage

// ---- sse_link_if.sv ----
// Pin-level link between the card reader and the secured EEPROM
`timescale 1ns/1ns
interface sse_link_if;
  logic rst_pin;
  logic clk_pin;
  logic program_strobe_pin;
  logic issuer_personalize_pin;
  logic host_io;
  logic host_io_oe_n;
  logic dev_io;
  logic dev_io_oe_n;
  logic io_line;

  // Open-drain data wire with pull-up
  assign io_line = (host_io_oe_n | host_io) & (dev_io_oe_n | dev_io);

  modport card (
    input  rst_pin,
    input  clk_pin,
    input  program_strobe_pin,
    input  issuer_personalize_pin,
    input  io_line,
    output dev_io,
    output dev_io_oe_n
  );

  modport reader (
    output rst_pin,
    output clk_pin,
    output program_strobe_pin,
    output issuer_personalize_pin,
    output host_io,
    output host_io_oe_n,
    input  io_line
  );
endinterface

// ---- sse_fifo.sv ----
// Small FIFO with registered output stage
`timescale 1ns/1ns
`include "sse_defines.svh"
module sse_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = `SSE_FIFO_DEPTH
) (
  input  wire logic             i_core_clk,  // Core clock
  input  wire logic             i_sys_rst,   // Async reset, high
  input  wire logic             i_in_valid,  // Write request
  input  wire logic [WIDTH-1:0] i_in_data,   // Write data
  output logic                  o_in_ready,  // Space available
  output logic                  o_out_valid, // Output word valid
  output logic [WIDTH-1:0]      o_out_data,  // Output word
  input  wire logic             i_out_ready  // Consumer takes word
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [PW:0]      cnt_ff;
  wire              push = i_in_valid & o_in_ready;
  wire              load = (cnt_ff != '0) & (~o_out_valid | i_out_ready);
  wire              drop = o_out_valid & i_out_ready & ~load;
  wire [PW:0]       nxt_cnt = cnt_ff + (PW+1)'(push) - (PW+1)'(load);

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr_ff   <= '0;
      rd_ptr_ff   <= '0;
      cnt_ff      <= '0;
      o_in_ready  <= 1'b1;
      o_out_valid <= 1'b0;
      o_out_data  <= '0;
    end else begin
      wr_ptr_ff  <= push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
      rd_ptr_ff  <= load ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
      cnt_ff     <= nxt_cnt;
      o_in_ready <= nxt_cnt < (PW+1)'(DEPTH);
      if (load) begin
        o_out_valid <= 1'b1;
        o_out_data  <= mem[rd_ptr_ff];
      end else if (drop) begin
        o_out_valid <= 1'b0;
      end
    end
  end
endmodule

// ---- sse_reader.sv ----
// Reader end: turns commands into pin sequences, buffers read bits
`timescale 1ns/1ns
`include "sse_defines.svh"
module sse_reader
  import sse_pkg::*;
#(
  parameter int HALF_CYC = `SSE_HALF_US * `SSE_CORE_MHZ,
  parameter int PROG_CYC = `SSE_PROG_MS * 1000 * `SSE_CORE_MHZ
) (
  input  wire logic       i_core_clk,   // Core clock, 20 MHz
  input  wire logic       i_sys_rst,    // Async reset, high
  sse_link_if.reader      lnk,          // Pins to the card
  input  wire logic       i_cmd_valid,  // Command request
  input  wire sse_pkg::cmd_t i_cmd,     // Command code
  input  wire logic       i_cmd_bit,    // Code bit for compare
  input  wire logic       i_pers,       // Personalize pin level
  output logic            o_cmd_ready,  // Ready for a command
  output logic            o_bit_valid,  // Sampled bit valid
  output logic            o_bit,        // Sampled data bit
  input  wire logic       i_bit_ready   // Consumer takes bit
);
  import sse_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_HIGH, ST_PROG, ST_LOW, ST_PUSH} st_t;

  st_t         st_ff;
  cmd_t        cmd_ff;
  logic        bit_ff;
  logic [31:0] tmr_ff;
  logic        rst_ff;
  logic        clk_ff;
  logic        pgm_ff;
  logic        oe_n_ff;
  logic        io1_ff;
  logic        io2_ff;
  logic        fifo_ready;

  wire is_prog = (cmd_ff == CMD_WRITE) | (cmd_ff == CMD_ERASE);
  wire t_half  = tmr_ff >= 32'(HALF_CYC);
  wire t_prog  = tmr_ff >= 32'(PROG_CYC);
  wire take    = (st_ff == ST_IDLE) & i_cmd_valid & fifo_ready;
  wire push    = (st_ff == ST_PUSH) & fifo_ready;
  wire drive0  = ((i_cmd == CMD_CMP) & ~i_cmd_bit) | (i_cmd == CMD_WRITE);

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      io1_ff <= 1'b1;
      io2_ff <= 1'b1;
    end else begin
      io1_ff <= lnk.io_line;
      io2_ff <= io1_ff;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff   <= ST_IDLE;
      cmd_ff  <= CMD_READ;
      bit_ff  <= 1'b0;
      tmr_ff  <= '0;
      rst_ff  <= 1'b1;
      clk_ff  <= 1'b0;
      pgm_ff  <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      tmr_ff <= tmr_ff + 32'd1;
      case (st_ff)
        ST_IDLE: begin
          tmr_ff <= '0;
          if (take) begin
            cmd_ff  <= i_cmd;
            st_ff   <= ST_SETUP;
            rst_ff  <= i_cmd == CMD_RESET;
            pgm_ff  <= (i_cmd == CMD_WRITE) | (i_cmd == CMD_ERASE);
            oe_n_ff <= ~drive0;
          end
        end
        ST_SETUP: begin
          if (t_half) begin
            tmr_ff <= '0;
            if (cmd_ff == CMD_RESET) begin
              rst_ff <= 1'b0;
              st_ff  <= ST_LOW;
            end else begin
              clk_ff <= 1'b1;
              st_ff  <= ST_HIGH;
            end
          end
        end
        ST_HIGH: begin
          if (t_half) begin
            tmr_ff <= '0;
            pgm_ff <= 1'b0;
            if (is_prog) begin
              st_ff <= ST_PROG;
            end else begin
              clk_ff  <= 1'b0;
              oe_n_ff <= 1'b1;
              st_ff   <= ST_LOW;
            end
          end
        end
        ST_PROG: begin
          if (t_prog) begin
            tmr_ff  <= '0;
            clk_ff  <= 1'b0;
            oe_n_ff <= 1'b1;
            st_ff   <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (t_half) begin
            bit_ff <= io2_ff;
            st_ff  <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (push) begin
            st_ff <= ST_IDLE;
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cmd_ready <= 1'b0;
    end else begin
      o_cmd_ready <= (st_ff == ST_IDLE) & ~take & fifo_ready;
    end
  end

  sse_fifo #(
    .WIDTH (1),
    .DEPTH (`SSE_FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (push),
    .i_in_data   (bit_ff),
    .o_in_ready  (fifo_ready),
    .o_out_valid (o_bit_valid),
    .o_out_data  (o_bit),
    .i_out_ready (i_bit_ready)
  );

  assign lnk.rst_pin                = rst_ff;
  assign lnk.clk_pin                = clk_ff;
  assign lnk.program_strobe_pin     = pgm_ff;
  assign lnk.issuer_personalize_pin = i_pers;
  assign lnk.host_io                = 1'b0;
  assign lnk.host_io_oe_n           = oe_n_ff;
endmodule

// ---- sse_link_asserts.sv ----
// Assertions on the reader-card link pins
`timescale 1ns/1ns
module sse_link_asserts #(
  parameter int PROG_CYC = 50
) (
  input wire logic i_core_clk,             // Core clock
  input wire logic i_sys_rst,              // Async reset, high
  input wire logic rst_pin,                // Reset pin
  input wire logic clk_pin,                // Serial clock pin
  input wire logic program_strobe_pin,     // Program strobe
  input wire logic issuer_personalize_pin, // Personalize pin
  input wire logic host_io,                // Reader data out
  input wire logic host_io_oe_n,           // Reader pulls low
  input wire logic dev_io,                 // Card data out
  input wire logic dev_io_oe_n,            // Card pulls low
  input wire logic io_line                 // Resolved data wire
);
  logic [31:0] high_cnt_ff;
  logic        arm_ff;
  logic        clk_d_ff;
  wire  [31:0] nxt_high_cnt = clk_pin ? high_cnt_ff + 32'h1 : 32'h0;
  wire         nxt_arm = (clk_pin & ~clk_d_ff) ? program_strobe_pin : (clk_pin & arm_ff);

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  // Clock high time of a program cycle
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      high_cnt_ff <= 32'h0;
      arm_ff <= 1'b0;
      clk_d_ff <= 1'b0;
    end else begin
      high_cnt_ff <= nxt_high_cnt;
      arm_ff <= nxt_arm;
      clk_d_ff <= clk_pin;
    end
  end

  property p_rst_fall_clk_low; $fell(rst_pin) |-> !clk_pin; endproperty
  a_rst_fall_clk_low: assert property (p_rst_fall_clk_low)
    else $error("reset pin fell with clock high");
  property p_strobe_drop; $fell(program_strobe_pin) |-> clk_pin; endproperty
  a_strobe_drop: assert property (p_strobe_drop)
    else $error("strobe dropped before clock rise");
  property p_prog_hold; $fell(clk_pin) && arm_ff |-> high_cnt_ff >= PROG_CYC; endproperty
  a_prog_hold: assert property (p_prog_hold)
    else $error("program clock high time too short");
  property p_prog_data; arm_ff && clk_pin && $past(clk_pin) |-> $stable(host_io_oe_n); endproperty
  a_prog_data: assert property (p_prog_data)
    else $error("program data changed while clock high");
  property p_strobe_rise; $rose(program_strobe_pin) |-> !clk_pin; endproperty
  a_strobe_rise: assert property (p_strobe_rise)
    else $error("strobe raised with clock high");
  property p_release_high; dev_io_oe_n && host_io_oe_n |-> io_line; endproperty
  a_release_high: assert property (p_release_high)
    else $error("released line not high");
  property p_open_drain; !dev_io && !host_io; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data driven high");
  property p_standby;
    (rst_pin && !program_strobe_pin && !issuer_personalize_pin) [*6] |-> dev_io_oe_n;
  endproperty
  a_standby: assert property (p_standby)
    else $error("card drives line in standby");
  property p_rise_release; $rose(clk_pin) |-> ##[2:6] dev_io_oe_n; endproperty
  a_rise_release: assert property (p_rise_release)
    else $error("card kept line at clock rise");
endmodule

// ---- secure_serial_eeprom_bit_access_tb.sv ----
// Bench joining reader and card ends across the link
`timescale 1ns/1ns
module secure_serial_eeprom_bit_access_tb;
  import sse_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, vld = 1'b0, cbit = 1'b0, brdy = 1'b0;
  logic        rd = 1'b0, wr = 1'b0, er = 1'b0, cl = 1'b0, cf = 1'b0, pers = 1'b0, fuse = 1'b1, sc = 1'b0;
  cmd_t        cmd = CMD_RESET;
  logic        cready, bvalid, bout, done, pdone, match, fail, fprot, stby, ok, m_fail, m_match;
  logic [13:0] addr, m_addr;
  logic        m_mem [0:63];
  logic        q [$];
  int          miscompares = 0, check_count = 0, dones = 0, m_dones = 0, pdones = 0, m_pdones = 0, k;

  sse_link_if lnk ();
  always #25 clk = ~clk;
  always @(negedge clk) if (done === 1'b1) dones <= dones + 1;
  always @(negedge clk) if (pdone === 1'b1) pdones <= pdones + 1;

  sse_card #(.PROG_CYC(50)) sse_card_inst (.i_core_clk(clk), .i_sys_rst(rst), .lnk(lnk.card), .i_rd_en(rd),
    .i_wr_en(wr), .i_er_en(er), .i_code_loc(cl), .i_cmp_flag_en(cf), .i_fuse_intact(fuse), .i_sc_valid(sc),
    .o_addr(addr), .o_cmp_done(done), .o_cmp_match(match), .o_cmp_fail(fail), .o_prog_done(pdone),
    .o_full_prot(fprot), .o_standby(stby));
  sse_reader #(.HALF_CYC(8), .PROG_CYC(60)) sse_reader_inst (.i_core_clk(clk), .i_sys_rst(rst), .lnk(lnk.reader),
    .i_cmd_valid(vld), .i_cmd(cmd), .i_cmd_bit(cbit), .i_pers(pers), .o_cmd_ready(cready),
    .o_bit_valid(bvalid), .o_bit(bout), .i_bit_ready(brdy));
  sse_link_asserts #(.PROG_CYC(50)) sse_link_asserts_inst (.i_core_clk(clk), .i_sys_rst(rst),
    .rst_pin(lnk.rst_pin), .clk_pin(lnk.clk_pin), .program_strobe_pin(lnk.program_strobe_pin),
    .issuer_personalize_pin(lnk.issuer_personalize_pin), .host_io(lnk.host_io), .host_io_oe_n(lnk.host_io_oe_n),
    .dev_io(lnk.dev_io), .dev_io_oe_n(lnk.dev_io_oe_n), .io_line(lnk.io_line));

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tmo();
    miscompares++;
    give_verdict();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected sampled bit; advances the model
  function automatic logic step(input cmd_t c, input logic b);
    logic op, rdok, cm;
    op = pers & fuse & sc;
    rdok = rd | op;
    cm = cl & cf & rdok;
    if (cm && (c == CMD_READ || c == CMD_CMP)) begin
      m_match = ((c == CMD_CMP ? b : 1'b1) === m_mem[m_addr[5:0]]);
      m_fail = m_fail | ~m_match;
      m_dones++;
    end
    if (c == CMD_WRITE || c == CMD_ERASE) m_pdones++;
    if (c == CMD_RESET) m_addr = 14'h0000;
    else if (c == CMD_READ || c == CMD_CMP) m_addr = m_addr + 14'h0001;
    else if (c == CMD_WRITE && (wr | op)) m_mem[m_addr[5:0]] = 1'b0;
    else if (c == CMD_ERASE && (er | op)) for (int i = 0; i < 8; i++) m_mem[{m_addr[5:3], 3'(i)}] = 1'b1;
    return (rdok && !cm) ? m_mem[m_addr[5:0]] : 1'b1;
  endfunction

  task automatic issue(input cmd_t c, input logic b, input int lim, output logic taken);
    int n;
    for (n = 0; n < lim && cready !== 1'b1; n++) @(negedge clk);
    taken = (n < lim);
    if (taken) begin
      cmd = c;
      cbit = b;
      vld = 1'b1;
      q.push_back(step(c, b));
      @(negedge clk);
      vld = 1'b0;
      @(negedge clk);
    end
  endtask

  task automatic pop();
    int n;
    for (n = 0; n < 500 && bvalid !== 1'b1; n++) @(negedge clk);
    if (n == 500) tmo();
    check(bout, q.pop_front());
    brdy = 1'b1;
    @(negedge clk);
    brdy = 1'b0;
    @(negedge clk);
  endtask

  task automatic op(input cmd_t c, input logic b);
    logic t;
    issue(c, b, 500, t);
    if (!t) tmo();
    pop();
    check(addr, m_addr);
    check(fail, m_fail);
    check(match, m_match);
    check(dones, m_dones);
    check(pdones, m_pdones);
    check(fprot, !(pers & fuse & sc));
  endtask

  task automatic sby(input logic e);
    for (int n = 0; n < 40 && stby !== e; n++) @(negedge clk);
    check(stby, e);
  endtask

  initial begin
    void'($urandom(32'hbf5073c1));
    {m_addr, m_fail, m_match} = 16'h0000;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check({addr, fail, fprot}, 16'h0001);
    sby(1'b1);
    op(CMD_RESET, 1'b0);
    sby(1'b0);
    er = 1'b1;
    op(CMD_ERASE, 1'b0);
    for (int i = 1; i < 64; i++) begin
      op(CMD_READ, 1'b0);
      if (m_addr[2:0] == 3'h0) op(CMD_ERASE, 1'b0);
    end
    $display("erase sweep done");
    {rd, wr, er} = 3'b110;
    op(CMD_RESET, 1'b0);
    op(CMD_WRITE, 1'b0);
    op(CMD_READ, 1'b0);
    op(CMD_WRITE, 1'b0);
    op(CMD_ERASE, 1'b0);
    er = 1'b1;
    op(CMD_ERASE, 1'b0);
    op(CMD_RESET, 1'b0);
    op(CMD_WRITE, 1'b0);
    rd = 1'b0;
    op(CMD_RESET, 1'b0);
    {rd, wr, pers, sc} = 4'b1011;
    op(CMD_READ, 1'b0);
    op(CMD_WRITE, 1'b0);
    op(CMD_READ, 1'b0);
    fuse = 1'b0;
    op(CMD_WRITE, 1'b0);
    {fuse, pers} = 2'b10;
    op(CMD_WRITE, 1'b0);
    {cl, cf} = 2'b11;
    op(CMD_CMP, 1'b0);
    op(CMD_RESET, 1'b0);
    {cl, cf} = 2'b00;
    $display("directed cases done");
    k = 0;
    ok = 1'b1;
    while (ok && k < 20) begin
      issue(CMD_READ, 1'b0, 300, ok);
      if (ok) k++;
    end
    check(k >= 8, 1);
    repeat (k) pop();
    check(bvalid, 0);
    $display("buffer fill done");
    op(CMD_RESET, 1'b0);
    for (int i = 0; i < 40; i++) begin
      {rd, wr, er, cl, cf, pers, fuse, sc} = 8'($urandom);
      op(cmd_t'($urandom_range(4, 1)), 1'($urandom));
    end
    $display("random cases done");
    {pers, cl, cf} = 3'b000;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    {m_addr, m_fail, m_match} = 16'h0000;
    check({addr, fail}, 15'h0000);
    sby(1'b1);
    op(CMD_RESET, 1'b0);
    $display("second reset done");
    give_verdict();
  end
endmodule
